/* verilog/ffmt_cfg.svh */
// offsets, field positions, reset values and timing for the ffmt block
// assumes a 100 MHz system clock and 8-bit register data
`ifndef FFMT_CFG_SVH
`define FFMT_CFG_SVH

// ********************
// register offsets
// ********************
`define FFMT_ADDR_THS 8'h17
`define FFMT_ADDR_COUNT 8'h18
`define FFMT_ADDR_X_HIGH 8'h73
`define FFMT_ADDR_X_LOW 8'h74
`define FFMT_ADDR_Y_HIGH 8'h75
`define FFMT_ADDR_Y_LOW 8'h76
`define FFMT_ADDR_Z_HIGH 8'h77
`define FFMT_ADDR_Z_LOW 8'h78

// ********************
// fields and resets
// ********************
`define FFMT_CLR_MODE_BIT 7
`define FFMT_ENABLE_BIT 7
`define FFMT_THS_HI_MSB 6
`define FFMT_THS_LO_MSB 5
`define FFMT_RESET_BYTE 8'h00

// ********************
// scaling and timing
// ********************
`define FFMT_MG_PER_G 1000
`define FFMT_COMMON_MG_PER_LSB 63
`define FFMT_COUNTS_PER_G_2G 4096
`define FFMT_CLK_PERIOD_NS 10
`define FFMT_STEP_BASE_NS 1250000
`define FFMT_CAP_NORMAL 16
`define FFMT_CAP_LOW_NOISE 64
`define FFMT_CAP_LP 128
`define FFMT_HIRES_MULT 2

`endif

/* verilog/ffmt_pkg.sv */
// types shared by the ffmt threshold and debounce block
// assumes nothing beyond a sv compiler
package ffmt_pkg;

	// ********************
	// mode encodings
	// ********************
	typedef enum logic [1:0] {
		PM_NORMAL,
		PM_LOW_POWER_LOW_NOISE,
		PM_HIGH_RES,
		PM_LOW_POWER
	} power_mode_e;

	typedef enum logic [2:0] {
		OSR_800,
		OSR_400,
		OSR_200,
		OSR_100,
		OSR_50,
		OSR_12P5,
		OSR_6P25,
		OSR_1P56
	} output_sample_rate_e;

endpackage

/* verilog/ffmt_step_timer.sv */
// debounce time step generator: one-cycle pulse every mult_i base steps
// assumes mult_i is at least one; a shrinking mult_i ends the step early
`timescale 1ns/10ps

module ffmt_step_timer #(
	parameter int BASE_CYCLES = 125000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// control
	input wire logic clear_i,
	input wire logic [7:0] mult_i,
	// step
	output logic step_o
);

	logic [16:0] base_q;
	logic [7:0] mult_q;
	logic base_tick;

	assign base_tick = (base_q == 17'(BASE_CYCLES - 1));

	// ********************
	// base divider
	// ********************
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			base_q <= 17'h0_0000;
		else if (clear_i || base_tick)
			base_q <= 17'h0_0000;
		else
			base_q <= base_q + 17'h0_0001;
	end

	// ********************
	// step multiple
	// ********************
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mult_q <= 8'h00;
			step_o <= 1'b0;
		end
		else if (clear_i)
		begin
			mult_q <= 8'h00;
			step_o <= 1'b0;
		end
		else
		begin
			// >= so a smaller multiple never strands the counter
			step_o <= base_tick && (mult_q >= mult_i - 8'h01);
			if (base_tick)
				mult_q <= (mult_q >= mult_i - 8'h01) ? 8'h00 :
					mult_q + 8'h01;
		end
	end

endmodule

/* verilog/freefall_motion_threshold_debounce.sv */
// free-fall / motion threshold compare and debounce with its registers
// assumes one sample_valid_i pulse per output sample, data synchronous
//
// Contract
// - each axis threshold is high bits 6..0 over low bits 5..0.
// - the common threshold is an unsigned 7-bit value used low or high.
// - polarity zero matches when every enabled axis is below threshold.
// - polarity one matches when any enabled axis is above threshold.
// - with per-axis enable each axis uses its own 13-bit threshold.
// - an 8-bit count holds the matching samples needed for an event.
// - the event flag sets when the debounce counter equals the count.
// - the debounce counter saturates at the programmed count.
// - the counter advances once per step set by the sample rate.
// - the step is capped by power mode, at two base steps in high resolution.
// - the clear-mode bit picks how a failing sample affects the count.
// - clear mode one zeroes the counter, zero decrements to zero.
// - the common threshold weighs 63 mg per count at any range.
// - per-axis thresholds are unsigned in output data resolution.
`timescale 1ns/10ps
`include "ffmt_cfg.svh"

module freefall_motion_threshold_debounce #(
	parameter int STEP_BASE_CYCLES = `FFMT_STEP_BASE_NS / `FFMT_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// configuration pins
	input wire logic detect_en_i,
	input wire logic polarity_i,
	input wire logic [2:0] axis_en_i,
	input wire logic [1:0] full_scale_i,
	input wire ffmt_pkg::output_sample_rate_e output_sample_rate_i,
	input wire ffmt_pkg::power_mode_e power_mode_i,
	// samples
	input wire logic sample_valid_i,
	input wire logic [13:0] x_data_i,
	input wire logic [13:0] y_data_i,
	input wire logic [13:0] z_data_i,
	// status
	output logic sample_match_o,
	output logic [7:0] debounce_count_o,
	output logic event_flag_o
);

	logic [7:0] ths_q;
	logic [7:0] count_q;
	logic [7:0] x_hi_q, x_lo_q, y_hi_q, y_lo_q, z_hi_q, z_lo_q;
	logic [12:0] x_thr, y_thr, z_thr;
	logic [2:0] below, above;
	logic per_axis, clr_mode, cfg_clear, step;
	logic [7:0] cnt_d;
	logic [7:0] step_mult;

	// ********************
	// helpers
	// ********************
	function automatic logic [13:0] abs14(input logic [13:0] v);
		abs14 = v[13] ? 14'(~v + 14'h0001) : v;
	endfunction

	// returns {below, above}; common threshold compared in milli-g terms
	function automatic logic [1:0] axis_cmp(input logic [13:0] a,
		input logic [12:0] thr, input logic use_axis,
		input logic [6:0] cth, input logic [1:0] fs);
		logic [26:0] lhs;
		logic [26:0] rhs;
		logic [1:0] fsh;
		fsh = (fs == 2'h3) ? 2'h2 : fs;
		if (use_axis)
		begin
			lhs = 27'(a);
			rhs = 27'(thr);
		end
		else
		begin
			lhs = 27'(a) * 27'(`FFMT_MG_PER_G);
			rhs = 27'(cth) * 27'(`FFMT_COMMON_MG_PER_LSB) *
				27'(`FFMT_COUNTS_PER_G_2G >> fsh);
		end
		axis_cmp = {lhs < rhs, lhs > rhs};
	endfunction

	function automatic logic [7:0] min8(input logic [7:0] a,
		input logic [7:0] b);
		min8 = (a < b) ? a : b;
	endfunction

	// ********************
	// threshold selection
	// ********************
	assign x_thr = {x_hi_q[`FFMT_THS_HI_MSB:0],
		x_lo_q[`FFMT_THS_LO_MSB:0]};
	assign y_thr = {y_hi_q[`FFMT_THS_HI_MSB:0],
		y_lo_q[`FFMT_THS_LO_MSB:0]};
	assign z_thr = {z_hi_q[`FFMT_THS_HI_MSB:0],
		z_lo_q[`FFMT_THS_LO_MSB:0]};
	assign per_axis = x_hi_q[`FFMT_ENABLE_BIT];
	assign clr_mode = ths_q[`FFMT_CLR_MODE_BIT];

	// common path scales 63 mg counts against data resolution
	assign {below[0], above[0]} = axis_cmp(abs14(x_data_i), x_thr, per_axis,
		ths_q[6:0], full_scale_i);
	assign {below[1], above[1]} = axis_cmp(abs14(y_data_i), y_thr, per_axis,
		ths_q[6:0], full_scale_i);
	assign {below[2], above[2]} = axis_cmp(abs14(z_data_i), z_thr, per_axis,
		ths_q[6:0], full_scale_i);

	// ********************
	// register file
	// ********************
	assign cfg_clear = !detect_en_i || reg_wr_i;

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ths_q <= `FFMT_RESET_BYTE;
			count_q <= `FFMT_RESET_BYTE;
			x_hi_q <= `FFMT_RESET_BYTE;
			x_lo_q <= `FFMT_RESET_BYTE;
			y_hi_q <= `FFMT_RESET_BYTE;
			y_lo_q <= `FFMT_RESET_BYTE;
			z_hi_q <= `FFMT_RESET_BYTE;
			z_lo_q <= `FFMT_RESET_BYTE;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `FFMT_ADDR_THS)
				ths_q <= reg_wdata_i;
			else if (reg_addr_i == `FFMT_ADDR_COUNT)
				count_q <= reg_wdata_i;
			else if (reg_addr_i == `FFMT_ADDR_X_HIGH)
				x_hi_q <= reg_wdata_i;
			else if (reg_addr_i == `FFMT_ADDR_X_LOW)
				x_lo_q <= {2'h0, reg_wdata_i[5:0]};
			else if (reg_addr_i == `FFMT_ADDR_Y_HIGH)
				y_hi_q <= reg_wdata_i;
			else if (reg_addr_i == `FFMT_ADDR_Y_LOW)
				y_lo_q <= {2'h0, reg_wdata_i[5:0]};
			else if (reg_addr_i == `FFMT_ADDR_Z_HIGH)
				z_hi_q <= {1'b0, reg_wdata_i[6:0]};
			else if (reg_addr_i == `FFMT_ADDR_Z_LOW)
				z_lo_q <= {2'h0, reg_wdata_i[5:0]};
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			if (reg_addr_i == `FFMT_ADDR_THS)
				reg_rdata_o <= ths_q;
			else if (reg_addr_i == `FFMT_ADDR_COUNT)
				reg_rdata_o <= count_q;
			else if (reg_addr_i == `FFMT_ADDR_X_HIGH)
				reg_rdata_o <= x_hi_q;
			else if (reg_addr_i == `FFMT_ADDR_X_LOW)
				reg_rdata_o <= x_lo_q;
			else if (reg_addr_i == `FFMT_ADDR_Y_HIGH)
				reg_rdata_o <= y_hi_q;
			else if (reg_addr_i == `FFMT_ADDR_Y_LOW)
				reg_rdata_o <= y_lo_q;
			else if (reg_addr_i == `FFMT_ADDR_Z_HIGH)
				reg_rdata_o <= z_hi_q;
			else if (reg_addr_i == `FFMT_ADDR_Z_LOW)
				reg_rdata_o <= z_lo_q;
			else
				reg_rdata_o <= 8'h00;
		end
	end

	// ********************
	// sample match
	// ********************
	// no enabled axis never matches, in either polarity
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			sample_match_o <= 1'b0;
		else if (cfg_clear)
			sample_match_o <= 1'b0;
		else if (sample_valid_i)
		begin
			if (polarity_i)
				sample_match_o <= |(above & axis_en_i);
			else
				sample_match_o <= (axis_en_i != 3'h0) &&
					((below & axis_en_i) == axis_en_i);
		end
	end

	// ********************
	// debounce step
	// ********************
	// natural sample period in 1.25 ms units, then the power mode cap
	always_comb
	begin
		step_mult = 8'h01 << output_sample_rate_i;
		if (output_sample_rate_i >= ffmt_pkg::OSR_12P5)
			step_mult = 8'h40 << (output_sample_rate_i - ffmt_pkg::OSR_12P5);
		if (output_sample_rate_i == ffmt_pkg::OSR_1P56)
			step_mult = 8'h80; // every mode caps before 512
		case (power_mode_i)
			ffmt_pkg::PM_NORMAL:
				step_mult = min8(step_mult, 8'(`FFMT_CAP_NORMAL));
			ffmt_pkg::PM_LOW_POWER_LOW_NOISE:
				step_mult = min8(step_mult, 8'(`FFMT_CAP_LOW_NOISE));
			ffmt_pkg::PM_HIGH_RES:
				step_mult = min8(step_mult, 8'(`FFMT_HIRES_MULT));
			default:
				step_mult = min8(step_mult, 8'(`FFMT_CAP_LP));
		endcase
	end

	ffmt_step_timer #(
		.BASE_CYCLES(STEP_BASE_CYCLES)
	) u_step (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(cfg_clear),
		.mult_i(step_mult),
		.step_o(step)
	);

	// ********************
	// debounce counter
	// ********************
	always_comb
	begin
		cnt_d = debounce_count_o;
		if (sample_match_o)
		begin
			if (debounce_count_o < count_q)
				cnt_d = debounce_count_o + 8'h01;
		end
		else if (clr_mode)
			cnt_d = 8'h00;
		else if (debounce_count_o != 8'h00)
			cnt_d = debounce_count_o - 8'h01;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			debounce_count_o <= 8'h00;
		else if (cfg_clear)
			debounce_count_o <= 8'h00;
		else if (step)
			debounce_count_o <= cnt_d;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			event_flag_o <= 1'b0;
		else if (cfg_clear)
			event_flag_o <= 1'b0;
		else if (step)
			event_flag_o <= sample_match_o && (cnt_d == count_q);
	end

	// ********************
	// assertions
	// ********************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_axis_thr_join: assert property (reg_wr_i && reg_addr_i ==
		`FFMT_ADDR_Y_LOW |=> y_thr[5:0] == $past(reg_wdata_i[5:0]))
		else $error("y threshold low bits not joined");
	a_low_g_all: assert property (sample_valid_i && !cfg_clear &&
		!polarity_i && axis_en_i == 3'h7 && below == 3'h7
		|=> sample_match_o)
		else $error("low-g sample not matched");
	a_high_g_any: assert property (sample_valid_i && !cfg_clear &&
		polarity_i && (above & axis_en_i) == 3'h0 |=> !sample_match_o)
		else $error("high-g match with no axis above");
	a_per_axis_thr: assert property (sample_valid_i && !cfg_clear &&
		per_axis && !polarity_i && axis_en_i == 3'h1 &&
		abs14(x_data_i) < 14'(x_thr) |=> sample_match_o)
		else $error("per-axis threshold ignored");
	a_cnt_saturate: assert property (debounce_count_o <= count_q ||
		$past(reg_wr_i))
		else $error("debounce counter past count");
	a_flag_at_count: assert property (step && !cfg_clear && sample_match_o &&
		debounce_count_o + 8'h01 == count_q |=> event_flag_o &&
		debounce_count_o == $past(count_q))
		else $error("event flag missed at count");
	a_cnt_on_step: assert property (!step && !cfg_clear
		|=> $stable(debounce_count_o))
		else $error("counter moved off step");
	a_clear_zero: assert property (step && !cfg_clear && !sample_match_o &&
		clr_mode |=> debounce_count_o == 8'h00)
		else $error("clear mode did not zero counter");
	a_clear_dec: assert property (step && !cfg_clear && !sample_match_o &&
		!clr_mode && debounce_count_o != 8'h00
		|=> debounce_count_o == $past(debounce_count_o) - 8'h01)
		else $error("decrement mode wrong");
	a_cfg_clears: assert property (reg_wr_i |=> debounce_count_o == 8'h00 &&
		!event_flag_o)
		else $error("reconfiguration left counter");
	a_hires_step: assert property (power_mode_i == ffmt_pkg::PM_HIGH_RES
		|-> step_mult <= 8'h02)
		else $error("high resolution step too long");

	c_event: cover property (!event_flag_o ##1 event_flag_o);
	c_decrement: cover property (step && !sample_match_o && !clr_mode &&
		debounce_count_o > 8'h01);
	c_per_axis_match: cover property (per_axis && sample_valid_i
		##1 sample_match_o);

endmodule

/* testbench/tb.sv */
// self-checking bench for the ffmt threshold and debounce block
// assumes the block alone, driven straight from its ports
`timescale 1ns/10ps

module tb;
	localparam int BASE = 4;
	logic clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_rd_i = 1'h0;
	logic detect_en_i = 1'h0;
	logic polarity_i = 1'h0;
	logic [2:0] axis_en_i = 3'h7;
	logic [1:0] full_scale_i = 2'h0;
	ffmt_pkg::output_sample_rate_e osr = ffmt_pkg::OSR_800;
	ffmt_pkg::power_mode_e pm = ffmt_pkg::PM_NORMAL;
	logic sample_valid_i = 1'h0;
	logic [13:0] x_data_i = 14'h0000;
	logic [13:0] y_data_i = 14'h0000;
	logic [13:0] z_data_i = 14'h0000;
	logic [7:0] reg_rdata_o;
	logic [7:0] debounce_count_o;
	logic sample_match_o;
	logic event_flag_o;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;

	freefall_motion_threshold_debounce #(.STEP_BASE_CYCLES(BASE)) DUT (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.detect_en_i(detect_en_i), .polarity_i(polarity_i),
		.axis_en_i(axis_en_i), .full_scale_i(full_scale_i),
		.output_sample_rate_i(osr), .power_mode_i(pm),
		.sample_valid_i(sample_valid_i), .x_data_i(x_data_i),
		.y_data_i(y_data_i), .z_data_i(z_data_i),
		.sample_match_o(sample_match_o),
		.debounce_count_o(debounce_count_o), .event_flag_o(event_flag_o));

	// ********************
	// clock, timeout, report
	// ********************
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// longest test (t_step) waits ~1830 cycles, whole run well under this
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			complete_run();
		end
	end

	task automatic chk_val(string what, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_bit(string what, logic e, logic g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask

	// ********************
	// port drivers
	// ********************
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick();
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'h1;
		tick();
		reg_wr_i = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		tick();
		reg_addr_i = a;
		reg_rd_i = 1'h1;
		tick();
		reg_rd_i = 1'h0;
		tick();
		chk_val($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata_o});
	endtask

	task automatic samp(input logic [13:0] x, y, z, input logic e);
		tick();
		x_data_i = x;
		y_data_i = y;
		z_data_i = z;
		sample_valid_i = 1'h1;
		tick();
		sample_valid_i = 1'h0;
		chk_bit("match", e, sample_match_o);
	endtask

	// waits for the next debounce counter move, bounded
	task automatic wait_chg();
		logic [7:0] old;
		int n;
		old = debounce_count_o;
		n = 0;
		while (debounce_count_o === old && n < 600)
		begin
			tick();
			n++;
		end
		if (n == 600)
		begin
			n_fail++;
			$display("ERROR step wait expected move seen none");
		end
	endtask

	task automatic chk_cnt(logic [7:0] c, logic f);
		chk_val("count", {8'h00, c}, {8'h00, debounce_count_o});
		chk_bit("flag", f, event_flag_o);
	endtask

	// ********************
	// scenarios
	// ********************
	task automatic t_regs();
		logic [7:0] a[8] = '{8'h17, 8'h18, 8'h73, 8'h74, 8'h75, 8'h76,
			8'h77, 8'h78};
		foreach (a[i]) rd(a[i], 8'h00);
		rd(8'h40, 8'h00);
		wr(8'h74, 8'hff);
		rd(8'h74, 8'h3f);
		wr(8'h77, 8'hff);
		rd(8'h77, 8'h7f);
		wr(8'h75, 8'h81);
		rd(8'h75, 8'h81);
		wr(8'h40, 8'h55);
		rd(8'h40, 8'h00);
		wr(8'h18, 8'ha5);
		rd(8'h18, 8'ha5);
		$display("test regs done");
	endtask

	// ths 1 at 2g is 258.048 counts, so 258 below and 259 above
	task automatic t_common();
		detect_en_i = 1'h1;
		wr(8'h75, 8'h00);
		wr(8'h77, 8'h00);
		wr(8'h73, 8'h00);
		wr(8'h17, 8'h01);
		polarity_i = 1'h0;
		samp(14'h0102, 14'h3efe, 14'h0000, 1'h1);
		samp(14'h0102, 14'h0103, 14'h0000, 1'h0);
		// 4g: 129.024 counts, 8g: 64.512 counts
		full_scale_i = 2'h1;
		samp(14'h0081, 14'h0000, 14'h0000, 1'h1);
		samp(14'h0082, 14'h0000, 14'h0000, 1'h0);
		full_scale_i = 2'h2;
		samp(14'h0040, 14'h0000, 14'h0000, 1'h1);
		samp(14'h0041, 14'h0000, 14'h0000, 1'h0);
		full_scale_i = 2'h0;
		axis_en_i = 3'h3;
		samp(14'h0000, 14'h0000, 14'h1000, 1'h1);
		axis_en_i = 3'h7;
		polarity_i = 1'h1;
		samp(14'h0103, 14'h0000, 14'h0000, 1'h1);
		samp(14'h0102, 14'h0102, 14'h0102, 1'h0);
		polarity_i = 1'h0;
		wr(8'h17, 8'h7f);
		samp(14'h1fff, 14'h1fff, 14'h2001, 1'h1);
		$display("test common done");
	endtask

	// x threshold 69, y 127, z 128
	task automatic t_axis();
		wr(8'h73, 8'h81);
		wr(8'h74, 8'h05);
		wr(8'h75, 8'h01);
		wr(8'h76, 8'h3f);
		wr(8'h77, 8'h02);
		wr(8'h78, 8'h00);
		polarity_i = 1'h1;
		samp(14'h0045, 14'h007f, 14'h0080, 1'h0);
		samp(14'h0046, 14'h0000, 14'h0000, 1'h1);
		samp(14'h0000, 14'h0080, 14'h0000, 1'h1);
		samp(14'h0000, 14'h0000, 14'h0081, 1'h1);
		samp(14'h3fba, 14'h0000, 14'h0000, 1'h1);
		polarity_i = 1'h0;
		samp(14'h0044, 14'h007e, 14'h007f, 1'h1);
		samp(14'h0044, 14'h007e, 14'h0080, 1'h0);
		axis_en_i = 3'h1;
		samp(14'h0044, 14'h1000, 14'h1000, 1'h1);
		axis_en_i = 3'h7;
		wr(8'h73, 8'h00);
		$display("test axis done");
	endtask

	task automatic t_debounce(input logic mode);
		wr(8'h17, {mode, 7'h01});
		wr(8'h18, 8'h02);
		chk_cnt(8'h00, 1'h0);
		samp(14'h0000, 14'h0000, 14'h0000, 1'h1);
		wait_chg();
		chk_cnt(8'h01, 1'h0);
		wait_chg();
		chk_cnt(8'h02, 1'h1);
		repeat (BASE * 3) tick();
		chk_cnt(8'h02, 1'h1);
		samp(14'h012c, 14'h0000, 14'h0000, 1'h0);
		wait_chg();
		chk_cnt(mode ? 8'h00 : 8'h01, 1'h0);
		if (!mode)
			wait_chg();
		repeat (BASE * 3) tick();
		chk_cnt(8'h00, 1'h0);
		$display("test debounce mode %0d done", mode);
	endtask

	task automatic t_step();
		logic [2:0] o[8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h2, 3'h4};
		logic [1:0] p[8] = '{2'h0, 2'h3, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2, 2'h2};
		int m[8] = '{1, 2, 8, 16, 64, 128, 2, 2};
		int c0;
		foreach (o[i])
		begin
			osr = ffmt_pkg::output_sample_rate_e'(o[i]);
			pm = ffmt_pkg::power_mode_e'(p[i]);
			detect_en_i = 1'h0;
			tick();
			tick();
			chk_cnt(8'h00, 1'h0);
			chk_bit("match", 1'h0, sample_match_o);
			detect_en_i = 1'h1;
			wr(8'h18, 8'h08);
			samp(14'h0000, 14'h0000, 14'h0000, 1'h1);
			wait_chg();
			c0 = cyc;
			wait_chg();
			chk_val("step", 16'(BASE * m[i]), 16'(cyc - c0));
		end
		$display("test step done");
	endtask

	initial
	begin
		repeat (6) @(posedge clk_i);
		#1;
		sys_rst_i = 1'h0;
		t_regs();
		t_common();
		t_axis();
		t_debounce(1'h1);
		t_debounce(1'h0);
		t_step();
		complete_run();
	end
endmodule
